// ===== logic/slt_defines.vh
`ifndef SLT_DEFINES_VH
`define SLT_DEFINES_VH

// Register byte offsets.
`define SLT_OFF_CTRL      8'h00
`define SLT_OFF_COUNTS    8'h04
`define SLT_OFF_INIT      8'h08
`define SLT_OFF_MIX       8'h0c
`define SLT_OFF_STATUS    8'h10
`define SLT_OFF_OUTPUT    8'h14
`define SLT_OFF_TABLE     8'h80

// Table memory word indices inside the table window.
`define SLT_TBL_VOL_BASE  5'h00
`define SLT_TBL_SPD_BASE  5'h10
`define SLT_TBL_PIT_BASE  5'h18

// Field positions.
`define SLT_CTRL_RUN      0
`define SLT_VOL_LSB       0
`define SLT_SPD_LSB       8
`define SLT_PIT_LSB       16
`define SLT_ST_VOL_BAD    24
`define SLT_ST_SPD_BAD    25
`define SLT_ST_PIT_BAD    26
`define SLT_ST_COMBO_BAD  27
`define SLT_ST_MIX_PITCH  28
`define SLT_ST_VALID      30
`define SLT_ST_RUN        31

// Level count limits and reset values.
`define SLT_VOL_MAX       4'd11
`define SLT_SPD_MAX       4'd7
`define SLT_PIT_MAX       4'd5
`define SLT_RST_COUNT     4'd1
`define SLT_RST_INDEX     4'd0
`define SLT_RST_MIX       7'h00

// Level codes.
`define SLT_VOL_FULL      7'h7f
`define SLT_CODE_OFF      8'h00
`define SLT_SPD_NARROW_LO 8'h55
`define SLT_SPD_NARROW_HI 8'h73

`endif

// ===== logic/slt_table_mem.v
`timescale 1ns/10ps
`default_nettype none

// Level table storage with a registered read port.
module slt_table_mem #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    // Clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // Write port
    input  wire             we,
    input  wire [AW-1:0]    waddr,
    input  wire [WIDTH-1:0] wdata,
    // Read port
    input  wire [AW-1:0]    raddr,
    output reg  [WIDTH-1:0] rdata
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];

    always @(posedge pclk)
    begin
        if (we)
            mem[waddr] <= wdata;
    end

    // Unwritten entries may read as unknown until software fills them.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rdata <= {WIDTH{1'b0}};
        else
            rdata <= mem[raddr];
    end

endmodule

`default_nettype wire

// ===== logic/slt_level_tables.v
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "slt_defines.vh"

// Operation
// RULE_01: Volume level count 1 to 11; only entries below count are used.
// RULE_02: Any of 128 volume codes may be placed in the volume table.
// RULE_03: Volume 0x7f is 0 dB, each step -0.5 dB, 0x00 silent, >=0x80 bad.
// RULE_04: At start the volume index equals the initial volume index.
// RULE_05: While mixing, channel 1 volume is channel 0 minus the attenuation.
// RULE_06: Step pins move among configured volume levels only.
// RULE_07: Speed level count 1 to 7; only entries below count are used.
// RULE_08: Speed codes 0x4b to 0x7d in 5% steps, 0x00 off, rest bad.
// RULE_09: Software keeps speed within 85 to 115% when pitch is used.
// RULE_10: Speed applies to channel 0; pitch narrows it to seven settings.
// RULE_11: At start the speed index equals the initial speed index.
// RULE_12: Pitch level count 1 to 5; only entries below count are used.
// RULE_13: Pitch codes 0x5a to 0x6e in 5% steps, 0x00 off, rest bad.
// RULE_14: At start the pitch index equals the initial pitch index.
// RULE_15: Pitch works on channel 0 only, in the pitch variant, five levels.
// RULE_16: Software sets all pitch entries to 0x00 when mixing is used.
// RULE_17: Pitch pairs only with speed 85 to 115%; else pitch must be off.
// RULE_18: Configuration loads at start and stays locked while running.
module slt_level_tables #(
    parameter PITCH_SUPPORT = 1
) (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Level step inputs, one-cycle pulses
    input  wire        vol_up,
    input  wire        vol_down,
    input  wire        speed_up,
    input  wire        speed_down,
    input  wire        pitch_up,
    input  wire        pitch_down,
    // Playback engine state
    input  wire        mix_active,
    // Playback engine settings
    output reg  [6:0]  vol_ch0_code,
    output reg  [6:0]  vol_ch0_atten,
    output reg         vol_ch0_mute,
    output reg  [6:0]  vol_ch1_code,
    output reg  [7:0]  speed_percent,
    output reg         speed_enable,
    output reg  [7:0]  pitch_percent,
    output reg         pitch_enable,
    output reg         levels_valid
);

    function [3:0] clamp_count;
        input [3:0] c;
        input [3:0] max;
        begin
            if (c == 4'd0)
                clamp_count = 4'd1;
            else if (c > max)
                clamp_count = max;
            else
                clamp_count = c;
        end
    endfunction

    function [3:0] clamp_idx;
        input [3:0] i;
        input [3:0] cnt;
        begin
            if (i >= cnt)
                clamp_idx = cnt - 4'd1;
            else
                clamp_idx = i;
        end
    endfunction

    // Opposite pulses in one cycle cancel rather than pick a winner.
    function [3:0] step_idx;
        input [3:0] i;
        input [3:0] cnt;
        input       up;
        input       dn;
        begin
            step_idx = i;
            if (up && !dn && (i + 4'd1 < cnt))
                step_idx = i + 4'd1;
            else if (dn && !up && (i != 4'd0))
                step_idx = i - 4'd1;
        end
    endfunction

    function tbl_mapped;
        input [4:0] w;
        begin
            tbl_mapped = (w < `SLT_TBL_VOL_BASE + `SLT_VOL_MAX) ||
                ((w >= `SLT_TBL_SPD_BASE) &&
                 (w < `SLT_TBL_SPD_BASE + {1'b0, `SLT_SPD_MAX})) ||
                ((w >= `SLT_TBL_PIT_BASE) &&
                 (w < `SLT_TBL_PIT_BASE + {1'b0, `SLT_PIT_MAX}));
        end
    endfunction

    function speed_ok;
        input [7:0] c;
        begin
            case (c)
                8'h00, 8'h4b, 8'h50, 8'h55, 8'h5a, 8'h5f, 8'h64,
                8'h69, 8'h6e, 8'h73, 8'h78, 8'h7d: speed_ok = 1'b1;
                default: speed_ok = 1'b0;
            endcase
        end
    endfunction

    function pitch_ok;
        input [7:0] c;
        begin
            case (c)
                8'h00, 8'h5a, 8'h5f, 8'h64, 8'h69, 8'h6e: pitch_ok = 1'b1;
                default: pitch_ok = 1'b0;
            endcase
        end
    endfunction

    localparam [2:0] SLOT_VOL = 3'b001;
    localparam [2:0] SLOT_SPD = 3'b010;
    localparam [2:0] SLOT_PIT = 3'b100;

    reg         run_q;
    reg  [3:0]  vol_cnt_q;
    reg  [3:0]  spd_cnt_q;
    reg  [3:0]  pit_cnt_q;
    reg  [3:0]  vol_init_q;
    reg  [3:0]  spd_init_q;
    reg  [3:0]  pit_init_q;
    reg  [6:0]  mix_atten_q;
    reg  [3:0]  vol_idx_q;
    reg  [3:0]  spd_idx_q;
    reg  [3:0]  pit_idx_q;
    reg  [2:0]  slot_q;
    reg  [2:0]  fetch_q;
    reg  [2:0]  fresh_q;
    reg  [7:0]  vol_raw_q;
    reg  [7:0]  spd_raw_q;
    reg  [7:0]  pit_raw_q;
    reg  [31:0] prdata_q;
    reg         tbl_rd_q;
    reg  [4:0]  slot_addr;
    reg         mapped;
    reg  [31:0] rd_mux;

    wire [7:0]  a        = paddr[7:0];
    wire        setup    = psel & ~penable;
    wire        access   = psel & penable;
    wire        hi_zero  = (paddr[11:8] == 4'h0) && (a[1:0] == 2'b00);
    wire        in_tbl   = hi_zero && a[7] && tbl_mapped(a[6:2]);
    wire        is_cfg   = in_tbl || (a == `SLT_OFF_COUNTS) ||
                           (a == `SLT_OFF_INIT) || (a == `SLT_OFF_MIX);
    wire        locked   = run_q & pwrite & is_cfg; // RULE_18
    wire        wr_ok    = access & pwrite & mapped & ~locked;
    wire        tbl_rd   = setup & ~pwrite & in_tbl;
    wire        start    = wr_ok && (a == `SLT_OFF_CTRL) &&
                           pwdata[`SLT_CTRL_RUN] && !run_q;
    wire [3:0]  vol_cnt  = clamp_count(vol_cnt_q, `SLT_VOL_MAX); // RULE_01
    wire [3:0]  spd_cnt  = clamp_count(spd_cnt_q, `SLT_SPD_MAX); // RULE_07
    wire [3:0]  pit_cnt  = clamp_count(pit_cnt_q, `SLT_PIT_MAX); // RULE_12
    wire [6:0]  ch0      = vol_ch0_code;
    wire [7:0]  mem_rdata;

    // Prohibited codes fall back to silence or to conversion off.
    wire       vol_good     = ~vol_raw_q[7]; // RULE_03
    wire [6:0] vol_code     = vol_good ? vol_raw_q[6:0] : 7'h00; // RULE_02
    wire       spd_good     = speed_ok(spd_raw_q); // RULE_08
    wire       speed_narrow = (spd_raw_q >= `SLT_SPD_NARROW_LO) &&
                              (spd_raw_q <= `SLT_SPD_NARROW_HI);
    wire       pitch_wanted = (PITCH_SUPPORT != 0) && !mix_active &&
                              pitch_ok(pit_raw_q) &&
                              (pit_raw_q != `SLT_CODE_OFF); // RULE_15 RULE_13
    // Speed keeps priority: an illegal pairing turns pitch off.
    wire       pitch_go     = pitch_wanted && speed_narrow; // RULE_10 RULE_17

    // Zero wait states: table reads fetch in setup and answer in access.
    assign pready  = 1'b1;
    assign pslverr = access & (~mapped | locked);
    assign prdata  = tbl_rd_q ? {24'h000000, mem_rdata} : prdata_q;

    always @*
    begin
        mapped = hi_zero && (in_tbl || (a == `SLT_OFF_CTRL) ||
                 (a == `SLT_OFF_COUNTS) || (a == `SLT_OFF_INIT) ||
                 (a == `SLT_OFF_MIX) || (a == `SLT_OFF_STATUS) ||
                 (a == `SLT_OFF_OUTPUT));
        rd_mux = 32'h00000000;
        case (a)
            `SLT_OFF_CTRL:
                rd_mux[`SLT_CTRL_RUN] = run_q;
            `SLT_OFF_COUNTS:
            begin
                rd_mux[`SLT_VOL_LSB +: 4] = vol_cnt_q;
                rd_mux[`SLT_SPD_LSB +: 3] = spd_cnt_q[2:0];
                rd_mux[`SLT_PIT_LSB +: 3] = pit_cnt_q[2:0];
            end
            `SLT_OFF_INIT:
            begin
                rd_mux[`SLT_VOL_LSB +: 4] = vol_init_q;
                rd_mux[`SLT_SPD_LSB +: 3] = spd_init_q[2:0];
                rd_mux[`SLT_PIT_LSB +: 3] = pit_init_q[2:0];
            end
            `SLT_OFF_MIX:
                rd_mux[6:0] = mix_atten_q;
            `SLT_OFF_STATUS:
            begin
                rd_mux[`SLT_VOL_LSB +: 4] = vol_idx_q;
                rd_mux[`SLT_SPD_LSB +: 3] = spd_idx_q[2:0];
                rd_mux[`SLT_PIT_LSB +: 3] = pit_idx_q[2:0];
                rd_mux[`SLT_ST_VOL_BAD] = run_q & vol_raw_q[7];
                rd_mux[`SLT_ST_SPD_BAD] = run_q & ~speed_ok(spd_raw_q);
                rd_mux[`SLT_ST_PIT_BAD] = run_q & ~pitch_ok(pit_raw_q);
                rd_mux[`SLT_ST_COMBO_BAD] = run_q & pitch_wanted &
                                            ~speed_narrow;
                rd_mux[`SLT_ST_MIX_PITCH] = run_q & mix_active &
                                            (pit_raw_q != `SLT_CODE_OFF);
                rd_mux[`SLT_ST_VALID] = levels_valid;
                rd_mux[`SLT_ST_RUN] = run_q;
            end
            `SLT_OFF_OUTPUT:
                rd_mux = {pitch_percent, speed_percent, 1'b0, vol_ch1_code,
                          1'b0, vol_ch0_code};
            default:
                rd_mux = 32'h00000000;
        endcase
    end

    // APB register file and the run latch.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_q       <= 1'b0;
            vol_cnt_q   <= `SLT_RST_COUNT;
            spd_cnt_q   <= `SLT_RST_COUNT;
            pit_cnt_q   <= `SLT_RST_COUNT;
            vol_init_q  <= `SLT_RST_INDEX;
            spd_init_q  <= `SLT_RST_INDEX;
            pit_init_q  <= `SLT_RST_INDEX;
            mix_atten_q <= `SLT_RST_MIX;
            prdata_q    <= 32'h00000000;
            tbl_rd_q    <= 1'b0;
        end
        else
        begin
            tbl_rd_q <= tbl_rd;
            if (setup)
                prdata_q <= (mapped && !pwrite) ? rd_mux : 32'h00000000;
            if (wr_ok && a == `SLT_OFF_CTRL)
                run_q <= pwdata[`SLT_CTRL_RUN];
            if (wr_ok && a == `SLT_OFF_COUNTS)
            begin
                vol_cnt_q <= pwdata[`SLT_VOL_LSB +: 4];
                spd_cnt_q <= {1'b0, pwdata[`SLT_SPD_LSB +: 3]};
                pit_cnt_q <= {1'b0, pwdata[`SLT_PIT_LSB +: 3]};
            end
            if (wr_ok && a == `SLT_OFF_INIT)
            begin
                vol_init_q <= pwdata[`SLT_VOL_LSB +: 4];
                spd_init_q <= {1'b0, pwdata[`SLT_SPD_LSB +: 3]};
                pit_init_q <= {1'b0, pwdata[`SLT_PIT_LSB +: 3]};
            end
            if (wr_ok && a == `SLT_OFF_MIX)
                mix_atten_q <= pwdata[6:0];
        end
    end

    // Selected indices: loaded on start, stepped by the pins while running.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vol_idx_q <= `SLT_RST_INDEX;
            spd_idx_q <= `SLT_RST_INDEX;
            pit_idx_q <= `SLT_RST_INDEX;
        end
        else if (start)
        begin
            vol_idx_q <= clamp_idx(vol_init_q, vol_cnt); // RULE_04
            spd_idx_q <= clamp_idx(spd_init_q, spd_cnt); // RULE_11
            pit_idx_q <= clamp_idx(pit_init_q, pit_cnt); // RULE_14
        end
        else if (run_q)
        begin
            vol_idx_q <= step_idx(vol_idx_q, vol_cnt, vol_up, vol_down); // RULE_06
            spd_idx_q <= step_idx(spd_idx_q, spd_cnt, speed_up, speed_down);
            pit_idx_q <= step_idx(pit_idx_q, pit_cnt, pitch_up, pitch_down);
        end
    end

    always @*
    begin
        case (slot_q)
            SLOT_VOL: slot_addr = `SLT_TBL_VOL_BASE + {1'b0, vol_idx_q};
            SLOT_SPD: slot_addr = `SLT_TBL_SPD_BASE + {1'b0, spd_idx_q};
            SLOT_PIT: slot_addr = `SLT_TBL_PIT_BASE + {1'b0, pit_idx_q};
            default:  slot_addr = `SLT_TBL_VOL_BASE;
        endcase
    end

    slt_table_mem #(
        .WIDTH (8),
        .DEPTH (32),
        .AW    (5)
    ) u_mem (
        .pclk    (pclk),
        .presetn (presetn),
        .we      (wr_ok & in_tbl),
        .waddr   (a[6:2]),
        .wdata   (pwdata[7:0]),
        .raddr   (tbl_rd ? a[6:2] : slot_addr),
        .rdata   (mem_rdata)
    );

    // Round-robin fetch of the selected entries; an APB table read steals
    // the port for one cycle, which only delays the rotation.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            slot_q    <= SLOT_VOL;
            fetch_q   <= 3'b000;
            fresh_q   <= 3'b000;
            vol_raw_q <= `SLT_CODE_OFF;
            spd_raw_q <= `SLT_CODE_OFF;
            pit_raw_q <= `SLT_CODE_OFF;
        end
        else
        begin
            // A fetch launched on the start edge still used the old index.
            fetch_q <= (tbl_rd || start) ? 3'b000 : slot_q;
            if (!tbl_rd)
                slot_q <= {slot_q[1:0], slot_q[2]};
            if (start)
                fresh_q <= 3'b000;
            else
                fresh_q <= fresh_q | fetch_q;
            if (fetch_q[0])
                vol_raw_q <= mem_rdata;
            if (fetch_q[1])
                spd_raw_q <= mem_rdata;
            if (fetch_q[2])
                pit_raw_q <= mem_rdata;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vol_ch0_code  <= 7'h00;
            vol_ch0_atten <= 7'h00;
            vol_ch0_mute  <= 1'b1;
            vol_ch1_code  <= 7'h00;
            speed_percent <= `SLT_CODE_OFF;
            speed_enable  <= 1'b0;
            pitch_percent <= `SLT_CODE_OFF;
            pitch_enable  <= 1'b0;
            levels_valid  <= 1'b0;
        end
        else
        begin
            vol_ch0_code  <= run_q ? vol_code : 7'h00;
            vol_ch0_atten <= (run_q && vol_code != 7'h00) ?
                             `SLT_VOL_FULL - vol_code : 7'h00; // RULE_03
            vol_ch0_mute  <= !run_q || vol_code == 7'h00;
            // Attenuation past the bottom code means silence.
            vol_ch1_code  <= (ch0 > mix_atten_q) ?
                             ch0 - mix_atten_q : 7'h00; // RULE_05
            speed_enable  <= run_q && spd_good &&
                             spd_raw_q != `SLT_CODE_OFF;
            speed_percent <= (run_q && spd_good) ?
                             spd_raw_q : `SLT_CODE_OFF;
            pitch_enable  <= run_q && pitch_go;
            pitch_percent <= (run_q && pitch_go) ?
                             pit_raw_q : `SLT_CODE_OFF;
            levels_valid  <= run_q && !start && (&fresh_q);
        end
    end

endmodule

`default_nettype wire

// ===== tb/slt_level_tables_props.sv
`timescale 1ns/10ps
`default_nettype none

// Relations between the level outputs; all are idle while in reset.
module slt_level_tables_props (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pslverr,
    // Engine side
    input wire logic        mix_active,
    input wire logic [6:0]  vol_ch0_code,
    input wire logic [6:0]  vol_ch0_atten,
    input wire logic        vol_ch0_mute,
    input wire logic [6:0]  vol_ch1_code,
    input wire logic [7:0]  speed_percent,
    input wire logic        speed_enable,
    input wire logic [7:0]  pitch_percent,
    input wire logic        pitch_enable,
    input wire logic        levels_valid
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    mute_code_a: assert property (vol_ch0_mute == (vol_ch0_code == 7'h00))
        else $error("mute differs from a zero volume code");
    atten_step_a: assert property (!vol_ch0_mute |->
        vol_ch0_atten == 7'h7f - vol_ch0_code)
        else $error("attenuation is not full scale minus code");
    mute_atten_a: assert property (vol_ch0_mute |-> vol_ch0_atten == 7'h00)
        else $error("attenuation set while muted");
    ch1_lower_a: assert property (vol_ch1_code <= $past(vol_ch0_code))
        else $error("channel 1 louder than channel 0");
    speed_code_a: assert property (speed_enable |-> speed_percent >= 8'h4b
        && speed_percent <= 8'h7d && (speed_percent - 8'h4b) % 5 == 0)
        else $error("speed code outside the legal steps");
    speed_off_a: assert property (!speed_enable |-> speed_percent == 8'h00)
        else $error("speed code shown while disabled");
    pitch_code_a: assert property (pitch_enable |-> pitch_percent >= 8'h5a
        && pitch_percent <= 8'h6e && (pitch_percent - 8'h5a) % 5 == 0)
        else $error("pitch code outside the legal steps");
    pitch_mix_a: assert property (mix_active [*8] |-> !pitch_enable)
        else $error("pitch active during mixing");
    pitch_pair_a: assert property (pitch_enable |-> speed_enable &&
        speed_percent >= 8'h55 && speed_percent <= 8'h73)
        else $error("pitch paired with a wide speed");
    unmapped_err_a: assert property (psel && penable && paddr[11:8] != 4'h0
        |-> pslverr)
        else $error("no error for an unmapped address");

    cover property ($rose(levels_valid));
    cover property (mix_active && vol_ch1_code != 7'h00);
    cover property (pitch_enable && speed_enable);
endmodule

`default_nettype wire

// ===== tb/slt_pin_model.sv
`timescale 1ns/10ps
`default_nettype none

// Stands for the step buttons and the engine's mixing state.
module slt_pin_model (
    // Clock
    input wire logic  pclk,
    // Step pins and engine state
    output wire logic vol_up,
    output wire logic vol_down,
    output wire logic speed_up,
    output wire logic speed_down,
    output wire logic pitch_up,
    output wire logic pitch_down,
    output var logic  mix_active
);
    logic [5:0] p = 6'h00;

    initial mix_active = 1'b0;
    assign {pitch_down, pitch_up, speed_down, speed_up, vol_down, vol_up} = p;

    // One-cycle pulse; a gap cycle follows so pulses stay distinct.
    task pulse(input int k);
        @(posedge pclk);
        p[k] <= 1'b1;
        @(posedge pclk);
        p <= 6'h00;
    endtask

    task mix(input logic m);
        @(posedge pclk);
        mix_active <= m;
    endtask
endmodule

`default_nettype wire

// ===== tb/test_slt_level_tables.sv
`timescale 1ns/10ps
`default_nettype none

module test_slt_level_tables;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire         vu, vd, su, sd, pu, pd, mix;
    wire  [6:0]  c0, at, c1;
    wire  [7:0]  sp, pt;
    wire         mute, se, pe, lv;
    int          n_mismatch;
    int          checked;
    int          cyc;
    logic [7:0]  vt [0:3] = '{8'h01, 8'h40, 8'h7f, 8'h11};
    // Narrow speeds only, since pitch is used.
    logic [7:0]  st [0:6] = '{8'h55, 8'h5a, 8'h5f, 8'h64, 8'h69, 8'h6e,
                              8'h73};
    logic [7:0]  ptb [0:4] = '{8'h5a, 8'h5f, 8'h64, 8'h69, 8'h6e};

    slt_level_tables #(.PITCH_SUPPORT(1)) u_slt_level_tables (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .vol_up(vu), .vol_down(vd),
        .speed_up(su), .speed_down(sd), .pitch_up(pu), .pitch_down(pd),
        .mix_active(mix), .vol_ch0_code(c0), .vol_ch0_atten(at),
        .vol_ch0_mute(mute), .vol_ch1_code(c1), .speed_percent(sp),
        .speed_enable(se), .pitch_percent(pt), .pitch_enable(pe),
        .levels_valid(lv));
    slt_pin_model u_slt_pin_model (
        .pclk(pclk), .vol_up(vu), .vol_down(vd), .speed_up(su),
        .speed_down(sd), .pitch_up(pu), .pitch_down(pd), .mix_active(mix));

    always #2 pclk = ~pclk;

    task finish_test;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cyc = cyc + 1;
        if (cyc == 5000)
        begin
            n_mismatch = n_mismatch + 1;
            finish_test;
        end
    end

    task chk(input logic [31:0] g, input logic [31:0] e);
        checked = checked + 1;
        if (g !== e)
        begin
            n_mismatch = n_mismatch + 1;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    // One APB transfer; read data and error are taken at the ready edge.
    task acc(input logic [11:0] a, input logic w, input logic [31:0] d,
             input logic [31:0] x, input logic ee);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        if (!w)
            chk(prdata, x);
        chk({31'h0, pslverr}, {31'h0, ee});
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task outs(input logic [6:0] e0, e1, input logic [7:0] es, ep);
        logic [6:0] ea;
        ea = (e0 == 7'h00) ? 7'h00 : 7'h7f - e0;
        chk({10'h0, c1, mute, at, c0}, {10'h0, e1, e0 == 7'h00, ea, e0});
        chk({14'h0, pe, pt, se, sp}, {14'h0, ep != 8'h00, ep, es != 8'h00, es});
    endtask

    task steps(input int k, input int n);
        repeat (n) u_slt_pin_model.pulse(k);
        repeat (10) @(posedge pclk);
    endtask

    task start;
        acc(12'h000, 1'b1, 32'h1, 32'h0, 1'b0);
        while (lv !== 1'b1)
            @(posedge pclk);
        repeat (10) @(posedge pclk);
    endtask

    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        n_mismatch = 0;
        checked = 0;
        cyc = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        acc(12'h004, 1'b0, 32'h0, 32'h00010101, 1'b0);
        acc(12'h008, 1'b0, 32'h0, 32'h0, 1'b0);
        acc(12'h104, 1'b0, 32'h0, 32'h0, 1'b1);
        outs(7'h00, 7'h00, 8'h00, 8'h00);
        for (int i = 0; i < 4; i++)
            acc(12'h080 + 12'(4 * i), 1'b1, {24'h0, vt[i]}, 32'h0, 1'b0);
        for (int i = 0; i < 7; i++)
            acc(12'h0c0 + 12'(4 * i), 1'b1, {24'h0, st[i]}, 32'h0, 1'b0);
        for (int i = 0; i < 5; i++)
            acc(12'h0e0 + 12'(4 * i), 1'b1, {24'h0, ptb[i]}, 32'h0, 1'b0);
        acc(12'h084, 1'b0, 32'h0, 32'h00000040, 1'b0);
        acc(12'h004, 1'b1, 32'h00050603, 32'h0, 1'b0);
        acc(12'h008, 1'b1, 32'h00020301, 32'h0, 1'b0);
        acc(12'h00c, 1'b1, 32'h14, 32'h0, 1'b0);
        start;
        acc(12'h010, 1'b0, 32'h0, 32'hc0020301, 1'b0);
        outs(7'h40, 7'h2c, 8'h64, 8'h64);
        acc(12'h014, 1'b0, 32'h0, 32'h64642c40, 1'b0);
        acc(12'h004, 1'b1, 32'h00010101, 32'h0, 1'b1);
        acc(12'h004, 1'b0, 32'h0, 32'h00050603, 1'b0);
        steps(0, 3);
        outs(7'h7f, 7'h6b, 8'h64, 8'h64);
        u_slt_pin_model.mix(1'b1);
        repeat (12) @(posedge pclk);
        outs(7'h7f, 7'h6b, 8'h64, 8'h00);
        acc(12'h010, 1'b0, 32'h0, 32'hd0020302, 1'b0);
        u_slt_pin_model.mix(1'b0);
        steps(1, 3);
        outs(7'h01, 7'h00, 8'h64, 8'h64);
        steps(2, 3);
        outs(7'h01, 7'h00, 8'h6e, 8'h64);
        steps(4, 3);
        outs(7'h01, 7'h00, 8'h6e, 8'h6e);
        steps(3, 6);
        steps(5, 5);
        outs(7'h01, 7'h00, 8'h55, 8'h5a);
        acc(12'h000, 1'b1, 32'h0, 32'h0, 1'b0);
        repeat (10) @(posedge pclk);
        outs(7'h00, 7'h00, 8'h00, 8'h00);
        acc(12'h084, 1'b1, 32'h80, 32'h0, 1'b0);
        acc(12'h0cc, 1'b1, 32'h00, 32'h0, 1'b0);
        start;
        outs(7'h00, 7'h00, 8'h00, 8'h00);
        acc(12'h010, 1'b0, 32'h0, 32'hc9020301, 1'b0);
        acc(12'h000, 1'b1, 32'h0, 32'h0, 1'b0);
        // Mixing again, this time with every pitch entry at zero.
        for (int i = 0; i < 5; i++)
            acc(12'h0e0 + 12'(4 * i), 1'b1, 32'h0, 32'h0, 1'b0);
        start;
        steps(0, 1);
        u_slt_pin_model.mix(1'b1);
        repeat (12) @(posedge pclk);
        outs(7'h7f, 7'h6b, 8'h00, 8'h00);
        acc(12'h010, 1'b0, 32'h0, 32'hc0020302, 1'b0);
        finish_test;
    end
endmodule

bind slt_level_tables slt_level_tables_props u_slt_level_tables_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .pslverr(pslverr), .mix_active(mix_active),
    .vol_ch0_code(vol_ch0_code), .vol_ch0_atten(vol_ch0_atten),
    .vol_ch0_mute(vol_ch0_mute), .vol_ch1_code(vol_ch1_code),
    .speed_percent(speed_percent), .speed_enable(speed_enable),
    .pitch_percent(pitch_percent), .pitch_enable(pitch_enable),
    .levels_valid(levels_valid));

`default_nettype wire
